// ==== core/atp_host_port.sv ====
// Adaptive four-bit host port with control, data and status registers
`timescale 1ns/1ps
`default_nettype none
`include "atp_consts.svh"
module atp_host_port #(
    parameter int DATA_W = 4
) (
    input  wire logic        ref_clk,       // 125 MHz core clock
    input  wire logic        sys_rst,       // Synchronous reset, high
    input  wire logic        cs_n,          // Chip select, low
    input  wire logic        data_strobe_in,// Data strobe or read strobe
    input  wire logic        rw_wr,         // Read/write line or write strobe
    input  wire logic        register_select, // Register select
    input  wire logic [3:0]  data_in,       // Data bus in
    output logic      [3:0]  data_out,      // Data bus out
    output logic             data_oe,       // Data bus drive enable
    output logic             interrupt_or_progress_pin_out, // Pin level, always 0
    output logic             interrupt_or_progress_pin_oe,  // High pulls pin low
    input  wire logic [3:0]  rx_code,       // Decoded received digit
    input  wire logic        rx_valid,      // Digit validated, pulse
    input  wire logic        tx_ready,      // Burst finished, pulse
    input  wire logic        steer_n,       // Delayed steering, low
    input  wire logic        status_aux,    // Extra status bit
    input  wire logic        cp_square,     // Call progress square wave
    output logic      [3:0]  tone_code,     // Tone pair code
    output logic             tone_load,     // New code, pulse
    output logic             tone_enable,   // Tone output enable
    output logic             cp_mode,       // Call progress mode
    output logic             column_select, // Column tone in single mode
    output logic             single_tone,   // Single tone mode
    output logic             test_mode,     // Test mode
    output logic             burst_disable  // Burst mode off
);
    atp_pkg::atp_state_t st_ff;
    atp_pkg::atp_state_t nxt_st;
    atp_pkg::atp_pins_t  raw_pins;
    atp_pkg::atp_pins_t  s;
    logic                act;
    logic                burst_on;
    logic                pull_low;

    generate
        if (DATA_W != 4) begin : g_chk
            $error("atp_host_port serves a four-bit bus only");
        end
    endgenerate

    assign raw_pins = '{cs_n: cs_n, strobe: data_strobe_in, dir: rw_wr,
                        sel: register_select, data: data_in};

    atp_sync #(
        .W ($bits(atp_pkg::atp_pins_t))
    ) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .d       (raw_pins),
        .q       (s)
    );

    // one qualifier for both host styles
    always_comb begin
        if (st_ff.proto == atp_pkg::ATP_PROTO_DS) begin
            act = !s.cs_n && s.strobe;
        end else begin
            act = !s.cs_n && (!s.strobe || !s.dir);
        end
    end

    // Next-state logic
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.tone_load = 1'b0;
        nxt_st.prev_cs_n = s.cs_n;
        burst_on         = !st_ff.ctrl_b[`ATP_CB_BURST_OFF];
        pull_low         = 1'b0;

        case (st_ff.phase)
            atp_pkg::ATP_IDLE: begin
                nxt_st.phase = atp_pkg::ATP_IDLE;
            end
            atp_pkg::ATP_SELECTED: begin
                if (s.cs_n) begin
                    nxt_st.phase = atp_pkg::ATP_IDLE;
                end else if (act) begin
                    nxt_st.phase = atp_pkg::ATP_STROBE;
                    nxt_st.wdata = s.data;
                    if (st_ff.proto == atp_pkg::ATP_PROTO_DS) begin
                        // separate bus: address valid with strobe
                        nxt_st.addr    = s.sel;
                        nxt_st.is_read = s.dir;
                    end else begin
                        nxt_st.is_read = !s.strobe;
                    end
                end
            end
            atp_pkg::ATP_STROBE: begin
                if (act) begin
                    nxt_st.wdata = s.data;
                end else begin
                    nxt_st.phase = s.cs_n ? atp_pkg::ATP_IDLE : atp_pkg::ATP_SELECTED;
                    if (!st_ff.is_read) begin
                        if (st_ff.addr == `ATP_SEL_DATA) begin
                            nxt_st.tx_code   = st_ff.wdata;
                            nxt_st.tone_load = 1'b1;
                        end else if (st_ff.ctrl_a[`ATP_CA_REDIRECT]) begin
                            // secondary write then back to primary
                            nxt_st.ctrl_b                    = st_ff.wdata;
                            nxt_st.ctrl_a[`ATP_CA_REDIRECT]  = 1'b0;
                        end else begin
                            nxt_st.ctrl_a = st_ff.wdata;
                        end
                    end else if (st_ff.addr == `ATP_SEL_CTRL) begin
                        // Status read acknowledges pending events
                        nxt_st.rx_pend = 1'b0;
                        nxt_st.tx_pend = 1'b0;
                    end
                end
            end
            default: begin
                nxt_st.phase = atp_pkg::ATP_IDLE;
            end
        endcase

        if (st_ff.prev_cs_n && !s.cs_n) begin
            nxt_st.phase = atp_pkg::ATP_SELECTED;
            if (s.strobe) begin
                nxt_st.proto = atp_pkg::ATP_PROTO_SEP;
                // multiplexed bus: address valid at the fall
                nxt_st.addr  = s.sel;
            end else begin
                nxt_st.proto = atp_pkg::ATP_PROTO_DS;
            end
        end

        // receive register; event set wins over read clear
        if (rx_valid) begin
            nxt_st.rx_data = rx_code;
            nxt_st.rx_pend = 1'b1;
        end
        if (tx_ready) begin
            nxt_st.tx_pend = 1'b1;
        end

        // status tracks state, frozen only while read
        if (!(st_ff.phase == atp_pkg::ATP_STROBE && st_ff.is_read)) begin
            nxt_st.status[`ATP_ST_STEER_N]  = steer_n;
            nxt_st.status[`ATP_ST_RX_VALID] = nxt_st.rx_pend;
            nxt_st.status[`ATP_ST_TX_EMPTY] = nxt_st.tx_pend;
            nxt_st.status[`ATP_ST_AUX]      = status_aux;
        end

        // read steering; write-only registers never read back
        nxt_st.d_oe  = (nxt_st.phase == atp_pkg::ATP_STROBE) && nxt_st.is_read;
        nxt_st.d_out = (nxt_st.addr == `ATP_SEL_CTRL) ? st_ff.status : st_ff.rx_data;

        // pin source chosen by mode bits
        if (nxt_st.ctrl_a[`ATP_CA_CP_MODE]) begin
            pull_low = nxt_st.ctrl_a[`ATP_CA_IRQ_EN] && !cp_square;
        end else if (nxt_st.ctrl_b[`ATP_CB_TEST]) begin
            pull_low = !steer_n;
        end else begin
            pull_low = nxt_st.ctrl_a[`ATP_CA_IRQ_EN]
                       && (nxt_st.rx_pend || (nxt_st.tx_pend && burst_on));
        end
        // open drain: drive low or release
        nxt_st.irq_oe  = pull_low;
        nxt_st.irq_out = 1'b0;
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff           <= '0;
            st_ff.proto     <= atp_pkg::ATP_PROTO_DS;
            st_ff.phase     <= atp_pkg::ATP_IDLE;
            st_ff.prev_cs_n <= 1'b1;
            st_ff.ctrl_a    <= `ATP_CA_RESET;
            st_ff.ctrl_b    <= `ATP_CB_RESET;
            st_ff.tx_code   <= `ATP_DATA_RESET;
            st_ff.rx_data   <= `ATP_DATA_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flops
    assign data_out                      = st_ff.d_out;
    assign data_oe                       = st_ff.d_oe;
    assign interrupt_or_progress_pin_out = st_ff.irq_out;
    assign interrupt_or_progress_pin_oe  = st_ff.irq_oe;
    assign tone_code                     = st_ff.tx_code;
    assign tone_load                     = st_ff.tone_load;
    assign tone_enable                   = st_ff.ctrl_a[`ATP_CA_TONE_EN];
    assign cp_mode                       = st_ff.ctrl_a[`ATP_CA_CP_MODE];
    assign column_select                 = st_ff.ctrl_b[`ATP_CB_COL_SEL];
    assign single_tone                   = st_ff.ctrl_b[`ATP_CB_SINGLE];
    assign test_mode                     = st_ff.ctrl_b[`ATP_CB_TEST];
    assign burst_disable                 = st_ff.ctrl_b[`ATP_CB_BURST_OFF];

    // Checks on the port behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic cs_fall;
    logic wr_end;
    assign cs_fall = st_ff.prev_cs_n && !s.cs_n;
    assign wr_end  = st_ff.phase == atp_pkg::ATP_STROBE && !act && !st_ff.is_read;

    property p_proto_ds;
        cs_fall && !s.strobe |=> st_ff.proto == atp_pkg::ATP_PROTO_DS;
    endproperty
    a_proto_ds: assert property (p_proto_ds) else $error("strobe protocol not sensed");

    property p_proto_sep;
        cs_fall && s.strobe |=> st_ff.proto == atp_pkg::ATP_PROTO_SEP
                                && st_ff.addr == $past(s.sel);
    endproperty
    a_proto_sep: assert property (p_proto_sep) else $error("split protocol not sensed");

    property p_tx_load;
        wr_end && st_ff.addr == `ATP_SEL_DATA
            |=> tone_load && tone_code == $past(st_ff.wdata) ##1 !tone_load;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("transmit load wrong");

    sequence s_arm;
        wr_end && st_ff.addr == `ATP_SEL_CTRL && !st_ff.ctrl_a[`ATP_CA_REDIRECT]
            && st_ff.wdata[`ATP_CA_REDIRECT];
    endsequence
    property p_redirect;
        s_arm |=> st_ff.ctrl_a[`ATP_CA_REDIRECT] && st_ff.ctrl_b == $past(st_ff.ctrl_b);
    endproperty
    a_redirect: assert property (p_redirect) else $error("redirect not armed");

    property p_second;
        wr_end && st_ff.addr == `ATP_SEL_CTRL && st_ff.ctrl_a[`ATP_CA_REDIRECT]
            |=> st_ff.ctrl_b == $past(st_ff.wdata) && !st_ff.ctrl_a[`ATP_CA_REDIRECT];
    endproperty
    a_second: assert property (p_second) else $error("secondary write wrong");

    property p_rx_hold;
        rx_valid |=> st_ff.rx_data == $past(rx_code) && st_ff.rx_pend;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("received digit lost");

    // First edge after reset still shows the reset status
    property p_status_live;
        st_ff.phase == atp_pkg::ATP_IDLE ##1 st_ff.phase == atp_pkg::ATP_IDLE
            && !$past(sys_rst)
            |-> st_ff.status[`ATP_ST_STEER_N] == $past(steer_n);
    endproperty
    a_status_live: assert property (p_status_live) else $error("status stale");

    property p_open_drain;
        !interrupt_or_progress_pin_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    property p_irq_rx;
        !cp_mode && !test_mode && st_ff.ctrl_a[`ATP_CA_IRQ_EN] && st_ff.rx_pend
            |-> interrupt_or_progress_pin_oe;
    endproperty
    a_irq_rx: assert property (p_irq_rx) else $error("digit interrupt missing");

    property p_read_drive;
        $rose(st_ff.phase == atp_pkg::ATP_STROBE) && st_ff.is_read
            |-> data_oe && data_out == (st_ff.addr ? $past(st_ff.status) : $past(st_ff.rx_data));
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data wrong");

    property p_qual_start;
        st_ff.phase == atp_pkg::ATP_SELECTED && act |=> st_ff.phase == atp_pkg::ATP_STROBE;
    endproperty
    a_qual_start: assert property (p_qual_start) else $error("access not started");

    property p_idle_hold;
        st_ff.phase == atp_pkg::ATP_IDLE && !cs_fall |=> st_ff.phase == atp_pkg::ATP_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("stray access");

    property p_addr_strobe;
        st_ff.phase == atp_pkg::ATP_SELECTED && act && st_ff.proto == atp_pkg::ATP_PROTO_DS
            |=> st_ff.addr == $past(s.sel) && st_ff.is_read == $past(s.dir);
    endproperty
    a_addr_strobe: assert property (p_addr_strobe) else $error("strobe address lost");

    property p_addr_split;
        st_ff.phase == atp_pkg::ATP_SELECTED && act && st_ff.proto == atp_pkg::ATP_PROTO_SEP
            |=> $stable(st_ff.addr) && st_ff.is_read == !$past(s.strobe);
    endproperty
    a_addr_split: assert property (p_addr_split) else $error("split address lost");

    property p_status_frozen;
        st_ff.phase == atp_pkg::ATP_STROBE && st_ff.is_read |=> $stable(st_ff.status);
    endproperty
    a_status_frozen: assert property (p_status_frozen) else $error("status moved");

    sequence s_status_end;
        st_ff.phase == atp_pkg::ATP_STROBE && !act && st_ff.is_read
            && st_ff.addr == `ATP_SEL_CTRL;
    endsequence
    property p_flag_clear;
        s_status_end ##0 (!rx_valid && !tx_ready) |=> !st_ff.rx_pend && !st_ff.tx_pend;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

    property p_write_quiet;
        !st_ff.is_read |-> !data_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("bus driven on write");

    property p_load_only;
        !(wr_end && st_ff.addr == `ATP_SEL_DATA) |=> !tone_load && $stable(tone_code);
    endproperty
    a_load_only: assert property (p_load_only) else $error("spurious tone load");

    property p_ctrl_hold;
        !wr_end |=> $stable(st_ff.ctrl_a) && $stable(st_ff.ctrl_b);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed");

    property p_cp_pin;
        st_ff.ctrl_a[`ATP_CA_CP_MODE] && st_ff.ctrl_a[`ATP_CA_IRQ_EN] && !wr_end
            |=> interrupt_or_progress_pin_oe == !$past(cp_square);
    endproperty
    a_cp_pin: assert property (p_cp_pin) else $error("progress wave wrong");

    property p_test_pin;
        !st_ff.ctrl_a[`ATP_CA_CP_MODE] && st_ff.ctrl_b[`ATP_CB_TEST] && !wr_end
            |=> interrupt_or_progress_pin_oe == !$past(steer_n);
    endproperty
    a_test_pin: assert property (p_test_pin) else $error("test pin wrong");

    property p_burst_quiet;
        !cp_mode && !test_mode && burst_disable && !st_ff.rx_pend && !rx_valid && !wr_end
            |=> !interrupt_or_progress_pin_oe;
    endproperty
    a_burst_quiet: assert property (p_burst_quiet) else $error("ready irq outside burst");

    property p_sync_lag;
        cs_fall |-> !$past(cs_n, 2);
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("select fall unsynchronised");
endmodule
`default_nettype wire

// ==== core/atp_consts.svh ====
// Constants of the adaptive tone host port: offsets, fields, reset values, counts
// How it works
// - Chip-select fall with strobe low: strobe-plus-direction protocol
// - Chip-select fall with read high: split strobes
// - Latch address and data per detected bus
// - One internal access qualifier for both protocols
// - Status register refreshes without any strobe activity
// - Select 0: tx/rx data; 1: control/status
// - Exactly five registers behind the port
// - Receive data read-only, holds last digit
// - Transmit data write-only, picks tone pair
// - Redirect bit sends next control write secondary
// - Status read-only, shows current transceiver state
// - Pin signals digit, tx ready, progress, or steering in test mode
// - Pin only pulls low or releases
// - Primary: redirect, irq enable, mode, tone enable
// - Secondary: column/row, single/dual, test, burst
// - Single-tone mode emits one group tone
// - Secondary write clears the redirect state
`ifndef ATP_CONSTS_SVH
`define ATP_CONSTS_SVH

// Register select decode
`define ATP_SEL_DATA      1'b0
`define ATP_SEL_CTRL      1'b1

// Primary control fields
`define ATP_CA_REDIRECT   3
`define ATP_CA_IRQ_EN     2
`define ATP_CA_CP_MODE    1
`define ATP_CA_TONE_EN    0

// Secondary control fields
`define ATP_CB_COL_SEL    3
`define ATP_CB_SINGLE     2
`define ATP_CB_TEST       1
`define ATP_CB_BURST_OFF  0

// Status fields
`define ATP_ST_STEER_N    3
`define ATP_ST_RX_VALID   2
`define ATP_ST_TX_EMPTY   1
`define ATP_ST_AUX        0

// Reset values
`define ATP_CA_RESET      4'h0
`define ATP_CB_RESET      4'h0
`define ATP_DATA_RESET    4'h0

// Synchroniser depth in clock cycles
`define ATP_SYNC_STAGES   2

`endif

// ==== core/atp_pkg.sv ====
// Types shared by the adaptive tone host port
package atp_pkg;

    // Host protocol sensed at the chip-select fall
    typedef enum logic [0:0] {
        ATP_PROTO_DS  = 1'b0,
        ATP_PROTO_SEP = 1'b1
    } atp_proto_t;

    // Access phase
    typedef enum logic [1:0] {
        ATP_IDLE     = 2'b00,
        ATP_SELECTED = 2'b01,
        ATP_STROBE   = 2'b10
    } atp_phase_t;

    // Host pins after synchronisation
    typedef struct packed {
        logic       cs_n;
        logic       strobe;    // Data strobe or read strobe
        logic       dir;       // Read/write line or write strobe
        logic       sel;
        logic [3:0] data;
    } atp_pins_t;

    // Whole state of the port
    typedef struct packed {
        atp_proto_t proto;
        atp_phase_t phase;
        logic       prev_cs_n;
        logic       is_read;
        logic       addr;
        logic [3:0] wdata;
        logic [3:0] ctrl_a;
        logic [3:0] ctrl_b;
        logic [3:0] tx_code;
        logic       tone_load;
        logic [3:0] rx_data;
        logic       rx_pend;
        logic       tx_pend;
        logic [3:0] status;
        logic [3:0] d_out;
        logic       d_oe;
        logic       irq_oe;
        logic       irq_out;
    } atp_state_t;

endpackage

// ==== core/atp_sync.sv ====
// Two-flop synchroniser for the host pins
`timescale 1ns/1ps
`default_nettype none
module atp_sync #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,  // Core clock
    input  wire logic         sys_rst,  // Synchronous reset
    input  wire logic [W-1:0] d,        // Raw pins
    output logic      [W-1:0] q         // Synchronised pins
);
    logic [W-1:0] meta_ff;

    generate
        if (W < 1) begin : g_chk
            $error("atp_sync width must be at least one");
        end
    endgenerate

    // First stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_ff <= '1;
            q       <= '1;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ==== bench/atp_host_model.sv ====
// Host processor model driving the port's bus pins
`timescale 1ns/1ps
`default_nettype none
module atp_host_model (
    input  wire logic       ref_clk,  // Core clock
    input  wire logic [3:0] data_out, // Read data from port
    input  wire logic       data_oe,  // Port drives bus
    output logic            cs_n,     // Chip select
    output logic            ds_rd,    // Data strobe or read strobe
    output logic            rw_wr,    // Direction or write strobe
    output logic            sel,      // Register select
    output logic      [3:0] d         // Bus toward port
);
    // Idle bus, chip select high
    initial begin
        cs_n = 1'b1;
        ds_rd = 1'b1;
        rw_wr = 1'b1;
        sel = 1'b0;
        d = 4'h0;
    end

    task automatic access(input logic split, input logic s, input logic rd,
                          input logic [3:0] wd, output logic [3:0] rq);
        @(posedge ref_clk);
        ds_rd <= split;
        rw_wr <= 1'b1;
        sel <= s;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        d <= wd;
        if (split && rd) ds_rd <= 1'b0;
        else if (split) rw_wr <= 1'b0;
        else begin
            ds_rd <= 1'b1;
            rw_wr <= rd;
        end
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rq = (data_oe === 1'b1) ? data_out : 4'hX;
        @(posedge ref_clk);
        ds_rd <= split;
        rw_wr <= 1'b1;
        d <= ~wd; // Released bus shows no stale value
        @(posedge ref_clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    // Write strobe with chip select never falling
    task automatic stray_write(input logic [3:0] wd);
        @(posedge ref_clk);
        rw_wr <= 1'b0;
        d <= wd;
        repeat (4) @(posedge ref_clk);
        rw_wr <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ==== bench/atp_host_port_tb.sv ====
// Self-checking bench for the adaptive tone host port
`timescale 1ns/1ps
`default_nettype none
module atp_host_port_tb;
    logic       ref_clk;
    logic       sys_rst;
    logic       cs_n;
    logic       ds;
    logic       rw;
    logic       rs;
    logic [3:0] din;
    logic [3:0] dout;
    logic       doe;
    logic       pin_out;
    logic       pin_oe;
    logic [3:0] rx_code;
    logic       rx_valid;
    logic       tx_ready;
    logic       steer_n;
    logic       status_aux;
    logic       cp_square;
    logic [3:0] tone_code;
    logic       tone_load;
    logic       tone_enable;
    logic       cp_mode;
    logic       column_select;
    logic       single_tone;
    logic       test_mode;
    logic       burst_disable;
    logic       pin;
    logic [3:0] q;
    int         err_count = 0;
    int         n_compared = 0;
    int         n_load = 0;

    // Pull-up on the open-drain pin
    assign pin = pin_oe ? pin_out : 1'b1;

    atp_host_model i_host (.ref_clk(ref_clk), .data_out(dout), .data_oe(doe), .cs_n(cs_n),
        .ds_rd(ds), .rw_wr(rw), .sel(rs), .d(din));

    atp_host_port i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n),
        .data_strobe_in(ds), .rw_wr(rw), .register_select(rs), .data_in(din),
        .data_out(dout), .data_oe(doe), .interrupt_or_progress_pin_out(pin_out),
        .interrupt_or_progress_pin_oe(pin_oe), .rx_code(rx_code), .rx_valid(rx_valid),
        .tx_ready(tx_ready), .steer_n(steer_n), .status_aux(status_aux),
        .cp_square(cp_square), .tone_code(tone_code), .tone_load(tone_load),
        .tone_enable(tone_enable), .cp_mode(cp_mode), .column_select(column_select),
        .single_tone(single_tone), .test_mode(test_mode), .burst_disable(burst_disable));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Count load pulses; a stuck pulse shows as extra counts
    always @(posedge ref_clk) begin
        if (!sys_rst && tone_load === 1'b1) n_load <= n_load + 1;
    end

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Compare once outputs have settled
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        @(negedge ref_clk);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic split, input logic s, input logic [3:0] v);
        logic [3:0] x;
        i_host.access(split, s, 1'b0, v, x);
    endtask

    task automatic rd(input logic split, input logic s);
        i_host.access(split, s, 1'b1, 4'h0, q);
    endtask

    // Receiver and transmitter event pulses
    task automatic ev(input logic rv, input logic tr, input logic [3:0] code);
        @(posedge ref_clk);
        rx_code <= code;
        rx_valid <= rv;
        tx_ready <= tr;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        tx_ready <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    // Hang guard, far above the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        test_done();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        rx_code = 4'h0;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
        steer_n = 1'b1;
        status_aux = 1'b1;
        cp_square = 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk({tone_enable, cp_mode, test_mode, pin}, 4'h1);
        // Transmit code through either host style
        wr(1'b1, 1'b0, 4'hA);
        chk(tone_code, 4'hA);
        wr(1'b0, 1'b0, 4'h5);
        chk(tone_code, 4'h5);
        chk(n_load[3:0], 4'h2);
        // Redirect to secondary, then back to primary
        wr(1'b1, 1'b1, 4'h9);
        chk({tone_enable, cp_mode, 2'b00}, 4'h8);
        wr(1'b0, 1'b1, 4'hE);
        chk({column_select, single_tone, test_mode, burst_disable}, 4'hE);
        wr(1'b1, 1'b1, 4'h4);
        chk({tone_enable, cp_mode, single_tone, test_mode}, 4'h3);
        // Test mode: pin follows steering
        @(posedge ref_clk);
        steer_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({3'b000, pin}, 4'h0);
        @(posedge ref_clk);
        steer_n <= 1'b1;
        wr(1'b0, 1'b1, 4'hC);
        wr(1'b0, 1'b1, 4'h0);
        chk({column_select, single_tone, test_mode, burst_disable}, 4'h0);
        chk({3'b000, pin}, 4'h1);
        // Digit and transmitter events without strobes
        ev(1'b1, 1'b1, 4'h9);
        chk({3'b000, pin}, 4'h0);
        rd(1'b0, 1'b0);
        chk(q, 4'h9);
        rd(1'b1, 1'b1);
        chk(q, 4'hF);
        chk({3'b000, pin}, 4'h1);
        rd(1'b0, 1'b1);
        chk(q, 4'h9);
        // Steering and spare status bits low
        @(posedge ref_clk);
        steer_n <= 1'b0;
        status_aux <= 1'b0;
        rd(1'b1, 1'b1);
        chk(q, 4'h0);
        @(posedge ref_clk);
        steer_n <= 1'b1;
        status_aux <= 1'b1;
        // Transmitter ready in burst mode
        ev(1'b0, 1'b1, 4'h3);
        chk({3'b000, pin}, 4'h0);
        rd(1'b1, 1'b1);
        chk(q, 4'hB);
        chk({3'b000, pin}, 4'h1);
        // Call progress square wave on the pin
        wr(1'b1, 1'b1, 4'h6);
        chk({2'b00, cp_mode, pin}, 4'h3);
        @(posedge ref_clk);
        cp_square <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({3'b000, pin}, 4'h0);
        @(posedge ref_clk);
        cp_square <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({3'b000, pin}, 4'h1);
        // Burst off: transmitter ready raises no interrupt
        wr(1'b1, 1'b1, 4'hC);
        wr(1'b0, 1'b1, 4'h1);
        chk({column_select, single_tone, test_mode, burst_disable}, 4'h1);
        ev(1'b0, 1'b1, 4'h3);
        chk({2'b00, cp_mode, pin}, 4'h1);
        rd(1'b1, 1'b1);
        chk(q, 4'hB);
        // Strobe with chip select high is ignored
        i_host.stray_write(4'h3);
        chk(tone_code, 4'h5);
        chk(n_load[3:0], 4'h2);
        test_done();
    end
endmodule
`default_nettype wire
